// file: src/spi_fifo_pkg.sv
// Shared constants and types for the serial port with circular buffer.
package spi_fifo_pkg;

    localparam logic [7:0] ADDR_CONTROL  = 8'h9a;
    localparam logic [7:0] ADDR_DATA     = 8'h9b;
    localparam logic [7:0] ADDR_RX_CTRL  = 8'h9c;
    localparam logic [7:0] ADDR_TX_CTRL  = 8'h9d;
    localparam logic [7:0] ADDR_START    = 8'h9e;
    localparam logic [7:0] ADDR_END      = 8'h9f;
    localparam logic [7:0] ADDR_PENDING  = 8'ha5;
    localparam logic [7:0] ADDR_AUX_EN   = 8'ha6;
    localparam logic [7:0] ADDR_AUX_STAT = 8'ha7;

    localparam int CTL_DIV_LSB = 5;
    localparam int CTL_FIFO    = 4;
    localparam int CTL_ORDER   = 3;
    localparam int CTL_MASTER  = 2;
    localparam int CTL_CPHA    = 1;
    localparam int CTL_CPOL    = 0;
    localparam int FLUSH_BIT   = 7;
    localparam int TC_CLK_EN   = 5;
    localparam int TC_OUTPUT_DRIVE_DELAY  = 4;
    localparam int TC_OUTPUT_DRIVE_ENABLE   = 3;
    localparam int AIE_TX      = 3;
    localparam int AIE_RX      = 2;

    // Index of each serial pin in the port latch and synchroniser vectors.
    localparam int PIN_SCLK = 3;
    localparam int PIN_MISO = 2;
    localparam int PIN_MOSI = 1;
    localparam int PIN_SS   = 0;

    localparam logic [6:0] PTR_RESET   = 7'h00;
    localparam logic [7:0] PTR_FLAG    = 8'h80;
    localparam logic [6:0] DBL_SPAN    = 7'h02;
    localparam logic [3:0] LAST_EDGE   = 4'hf;
    localparam logic [7:0] FILL_BYTE   = 8'hff;
    localparam logic [3:0] PEND_NONE   = 4'h0;
    localparam logic [3:0] PEND_RX     = 4'h3;
    localparam logic [3:0] PEND_TX     = 4'h4;
    localparam int         RAM_DEPTH   = 128;

    typedef enum logic {ST_IDLE, ST_XFER} state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sfr_req_t;

    typedef struct packed {
        logic sclk;
        logic miso;
        logic mosi;
        logic ss_n;
    } pin_in_t;

    typedef struct packed {
        logic sclk;
        logic sclk_oe_n;
        logic mosi;
        logic mosi_oe_n;
        logic miso;
        logic miso_oe_n;
    } pin_out_t;

endpackage : spi_fifo_pkg

// file: src/spi_fifo_port.sv
// Serial port engine with register port, circular buffer in indirect RAM and pins.
//
// Overview of operation
// - Control write resets engine, counts and pointers.
// - Master clock is system clock over 2..256.
// - Mode bit picks double buffer or circular FIFO.
// - Order bit picks MSB or LSB first.
// - Role bit: 0 slave, 1 master.
// - Phase sets data valid before or at edge.
// - Polarity sets clock idle low or high.
// - Data address writes transmit, reads receive.
// - Receive control read gives receive count.
// - Writing receive flush one empties receive.
// - Receive interrupt when count at least 2^n.
// - Transmit control read gives transmit count.
// - Transmit flush sets pointer to output pointer.
// - Master clock driver follows clock enable bit.
// - Data drive changes now or after byte.
// - Transmit interrupt when count at most 2^n.
// - Start address write clears both counts.
// - Transmit pointer advances unless hitting receive pointer.
// - Pointers wrap from end (start plus 2 in double buffer mode) back to start.
// - Receive pointer advances on read while nonempty.
// - Pending code 3 receive, 4 transmit.
// - Enable write masks, read returns raw state.
// - Pin drivers and the select input serve only with port latch set.
// - Aux status shows active unmasked interrupts, transmit and receive.
`timescale 1ns/10ps

module spi_fifo_port (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire spi_fifo_pkg::sfr_req_t sfr,
    output logic [7:0]                 sfr_rdata,
    input  wire logic [3:0]            port1_latch,
    input  wire spi_fifo_pkg::pin_in_t pins_in,
    output spi_fifo_pkg::pin_out_t     pins_out,
    output logic                       aux_irq
);
    import spi_fifo_pkg::*;

    typedef struct packed {
        state_t                      fsm;
        logic [7:0]                  ctrl;
        logic [2:0]                  rx_thr;
        logic [2:0]                  tx_thr;
        logic                        clk_en;
        logic                        drv_on;
        logic                        drv_wait;
        logic                        drv_pend;
        logic [6:0]                  lo;
        logic [6:0]                  end_addr;
        logic [6:0]                  tp;
        logic [6:0]                  op;
        logic [6:0]                  wp;
        logic [6:0]                  rp;
        logic [7:0]                  tx_sr;
        logic [7:0]                  rx_sr;
        logic [3:0]                  edge_idx;
        logic [7:0]                  div_cnt;
        logic                        sck;
        logic [1:0][7:0]             rxq;
        logic [1:0]                  rxq_cnt;
        logic                        tx_ie;
        logic                        rx_ie;
        logic [3:0]                  s1;
        logic [3:0]                  s2;
        logic                        sclk_prev;
        logic [7:0]                  rdata;
        pin_out_t                    pins;
        logic                        irq;
        logic [RAM_DEPTH-1:0][7:0]   mem;
    } regs_t;

    regs_t      q;
    regs_t      n;
    logic [6:0] hi;
    logic [7:0] tx_cnt;
    logic [7:0] rx_cnt;
    logic       rx_irq;
    logic       tx_irq;
    logic [3:0] pend_code;
    logic       tick;
    logic       dwr;

    function automatic logic [6:0] ring_inc(input logic [6:0] p, input logic [6:0] lo,
                                            input logic [6:0] top);
        return (p == top) ? lo : p + 7'd1;
    endfunction : ring_inc

    function automatic logic [7:0] ring_dist(input logic [6:0] a, input logic [6:0] b,
                                             input logic [6:0] lo, input logic [6:0] top);
        logic [7:0] size;
        size = {1'b0, top} - {1'b0, lo} + 8'd1;
        if (b >= a)
            return {1'b0, b} - {1'b0, a};
        return size - ({1'b0, a} - {1'b0, b});
    endfunction : ring_dist

    function automatic logic is_write(input sfr_req_t r, input logic [7:0] a);
        return r.wr && (r.addr == a);
    endfunction : is_write

    ////////////////////////////////////////////////////////////////////////////////
    // Derived status.

    always_comb begin
        // Double buffer mode keeps a three-slot ring so two bytes fit in total.
        hi        = q.ctrl[CTL_FIFO] ? q.end_addr : q.lo + DBL_SPAN;
        tx_cnt    = ring_dist(q.op, q.tp, q.lo, hi);
        rx_cnt    = ring_dist(q.rp, q.wp, q.lo, hi);
        rx_irq    = rx_cnt >= (8'd1 << q.rx_thr);
        tx_irq    = tx_cnt <= (8'd1 << q.tx_thr);
        // Receive outranks transmit, as lower codes are served first.
        if (rx_irq && q.rx_ie)
            pend_code = PEND_RX;
        else if (tx_irq && q.tx_ie)
            pend_code = PEND_TX;
        else
            pend_code = PEND_NONE;
        if (q.ctrl[CTL_MASTER])
            tick = (q.fsm == ST_XFER) &&
                   (q.div_cnt == (8'd1 << q.ctrl[CTL_DIV_LSB +: 3]) - 8'd1);
        else
            tick = (q.fsm == ST_XFER) && (q.s2[PIN_SCLK] != q.sclk_prev);
        dwr = is_write(sfr, ADDR_DATA);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic       master;
        logic       cpha;
        logic       lsb;
        logic       ss_act;
        logic       in_bit;
        logic [6:0] tp_inc;
        master = q.ctrl[CTL_MASTER];
        cpha   = q.ctrl[CTL_CPHA];
        lsb    = q.ctrl[CTL_ORDER];
        ss_act = !q.s2[PIN_SS] && port1_latch[PIN_SS];
        in_bit = master ? q.s2[PIN_MISO] : q.s2[PIN_MOSI];
        tp_inc = ring_inc(q.tp, q.lo, hi);
        n = q;
        n.s1        = pins_in;
        n.s2        = q.s1;
        n.sclk_prev = q.s2[PIN_SCLK];

        // Software writes into the ring at the transmit pointer.
        if (dwr) begin
            n.mem[q.tp] = sfr.wdata;
            if (tp_inc != q.rp)
                n.tp = tp_inc;
        end

        // Drain the receive skid buffer into the ring. A slot is free once its byte
        // went out; with nothing queued, transmit and output pointers move along too.
        if (!dwr && q.rxq_cnt != 2'd0 &&
            (q.wp != q.op || (q.op == q.tp && tp_inc != q.rp))) begin
            n.mem[q.wp] = q.rxq[0];
            n.wp        = ring_inc(q.wp, q.lo, hi);
            if (q.wp == q.op) begin
                n.op = ring_inc(q.op, q.lo, hi);
                n.tp = tp_inc;
            end
            n.rxq[0]  = q.rxq[1];
            n.rxq_cnt = q.rxq_cnt - 2'd1;
        end

        if (sfr.rd && sfr.addr == ADDR_DATA && rx_cnt != 8'd0)
            n.rp = ring_inc(q.rp, q.lo, hi);

        case (q.fsm)
            ST_IDLE: begin
                n.sck      = q.ctrl[CTL_CPOL];
                n.div_cnt  = 8'd0;
                n.edge_idx = 4'd0;
                // The master waits for data and for room in the skid buffer.
                if ((master && tx_cnt != 8'd0 && q.rxq_cnt != 2'd2) ||
                    (!master && ss_act)) begin
                    n.fsm = ST_XFER;
                    if (q.op != q.tp) begin
                        n.tx_sr = q.mem[q.op];
                        n.op    = ring_inc(q.op, q.lo, hi);
                    end else begin
                        n.tx_sr = FILL_BYTE;
                    end
                end
            end
            ST_XFER: begin
                if (!master && !ss_act) begin
                    n.fsm = ST_IDLE;
                end else if (tick) begin
                    n.div_cnt  = 8'd0;
                    n.sck      = ~q.sck;
                    n.edge_idx = q.edge_idx + 4'd1;
                    if (q.edge_idx[0] == cpha)
                        n.rx_sr = lsb ? {in_bit, q.rx_sr[7:1]} : {q.rx_sr[6:0], in_bit};
                    else if (q.edge_idx != 4'd0 && q.edge_idx != LAST_EDGE)
                        n.tx_sr = lsb ? {1'b1, q.tx_sr[7:1]} : {q.tx_sr[6:0], 1'b1};
                    if (q.edge_idx == LAST_EDGE) begin
                        n.fsm = ST_IDLE;
                        // A full skid buffer in slave mode drops the byte: overrun.
                        if (n.rxq_cnt != 2'd2) begin
                            n.rxq[n.rxq_cnt[0]] = n.rx_sr;
                            n.rxq_cnt           = n.rxq_cnt + 2'd1;
                        end
                        if (q.drv_wait) begin
                            n.drv_on   = q.drv_pend;
                            n.drv_wait = 1'b0;
                        end
                    end
                end else if (master) begin
                    n.div_cnt = q.div_cnt + 8'd1;
                end
            end
            default: n.fsm = ST_IDLE;
        endcase

        // Register writes come last so that their resets override the engine.
        if (is_write(sfr, ADDR_CONTROL)) begin
            n.ctrl     = sfr.wdata;
            n.fsm      = ST_IDLE;
            n.tp       = q.lo;
            n.op       = q.lo;
            n.wp       = q.lo;
            n.rp       = q.lo;
            n.rxq_cnt  = 2'd0;
            n.edge_idx = 4'd0;
            n.sck      = sfr.wdata[CTL_CPOL];
        end
        if (is_write(sfr, ADDR_RX_CTRL)) begin
            n.rx_thr = sfr.wdata[2:0];
            if (sfr.wdata[FLUSH_BIT])
                n.rp = n.wp;
        end
        if (is_write(sfr, ADDR_TX_CTRL)) begin
            n.tx_thr = sfr.wdata[2:0];
            n.clk_en = sfr.wdata[TC_CLK_EN];
            if (sfr.wdata[FLUSH_BIT])
                n.tp = n.op;
            if (sfr.wdata[TC_OUTPUT_DRIVE_DELAY]) begin
                n.drv_pend = sfr.wdata[TC_OUTPUT_DRIVE_ENABLE];
                n.drv_wait = 1'b1;
            end else begin
                n.drv_on   = sfr.wdata[TC_OUTPUT_DRIVE_ENABLE];
                n.drv_wait = 1'b0;
            end
        end
        if (is_write(sfr, ADDR_START) || is_write(sfr, ADDR_END)) begin
            if (is_write(sfr, ADDR_START))
                n.lo = sfr.wdata[6:0];
            else
                n.end_addr = sfr.wdata[6:0];
            n.tp      = n.lo;
            n.op      = n.lo;
            n.wp      = n.lo;
            n.rp      = n.lo;
            n.rxq_cnt = 2'd0;
        end
        if (is_write(sfr, ADDR_AUX_EN)) begin
            n.tx_ie = sfr.wdata[AIE_TX];
            n.rx_ie = sfr.wdata[AIE_RX];
        end

        if (sfr.rd) begin
            case (sfr.addr)
                ADDR_CONTROL:  n.rdata = q.ctrl;
                ADDR_DATA:     n.rdata = q.mem[q.rp];
                ADDR_RX_CTRL:  n.rdata = rx_cnt;
                ADDR_TX_CTRL:  n.rdata = tx_cnt;
                ADDR_START:    n.rdata = PTR_FLAG | {1'b0, q.tp};
                ADDR_END:      n.rdata = PTR_FLAG | {1'b0, q.rp};
                ADDR_PENDING:  n.rdata = {4'h0, pend_code};
                ADDR_AUX_EN:   n.rdata = {4'h0, tx_irq, rx_irq, 2'b00};
                ADDR_AUX_STAT: n.rdata = {4'h0, tx_irq && q.tx_ie, rx_irq && q.rx_ie, 2'b00};
                default:       n.rdata = 8'h00;
            endcase
        end

        n.irq = (pend_code != PEND_NONE);
        n.pins.sclk      = n.sck;
        n.pins.sclk_oe_n = !(n.ctrl[CTL_MASTER] && n.clk_en && port1_latch[PIN_SCLK]);
        n.pins.mosi      = n.ctrl[CTL_ORDER] ? n.tx_sr[0] : n.tx_sr[7];
        n.pins.miso      = n.pins.mosi;
        n.pins.mosi_oe_n = !(n.ctrl[CTL_MASTER] && n.drv_on && port1_latch[PIN_MOSI]);
        n.pins.miso_oe_n = !(!n.ctrl[CTL_MASTER] && n.drv_on && ss_act &&
                             port1_latch[PIN_MISO]);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Drivers stay off and the select line reads idle while in reset, so
            // nothing fights the pins and no false slave frame starts on release.
            q                <= '0;
            q.pins.sclk_oe_n <= 1'b1;
            q.pins.mosi_oe_n <= 1'b1;
            q.pins.miso_oe_n <= 1'b1;
            q.s1[PIN_SS]     <= 1'b1;
            q.s2[PIN_SS]     <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign sfr_rdata = q.rdata;
    assign pins_out  = q.pins;
    assign aux_irq   = q.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic [12:0] xfer_cycles;

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            xfer_cycles <= 13'd0;
        else if (q.fsm == ST_XFER)
            xfer_cycles <= xfer_cycles + 13'd1;
        else
            xfer_cycles <= 13'd0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence seq_ctrl_write;
        is_write(sfr, ADDR_CONTROL);
    endsequence

    sequence seq_engine_cleared;
        q.fsm == ST_IDLE && q.tp == q.lo && q.op == q.lo && q.rp == q.lo && q.wp == q.lo;
    endsequence

    sequence seq_master_last_edge;
        q.ctrl[CTL_MASTER] && tick && q.edge_idx == LAST_EDGE && !sfr.wr;
    endsequence

    a_ctrl_write_reset: assert property (seq_ctrl_write |=> seq_engine_cleared)
        else $error("control write did not reset engine");
    a_master_byte_time: assert property (seq_master_last_edge |->
        xfer_cycles == ((13'd16 << q.ctrl[CTL_DIV_LSB +: 3]) - 13'd1) ##1 q.fsm == ST_IDLE)
        else $error("master byte length wrong");
    a_sclk_idle_level: assert property ((q.fsm == ST_IDLE && $past(q.fsm) == ST_IDLE)
        |-> pins_out.sclk == q.ctrl[CTL_CPOL])
        else $error("serial clock not at idle level");
    a_clk_drv_gate: assert property (!q.clk_en |-> pins_out.sclk_oe_n)
        else $error("clock driver on while disabled");
    a_drv_immediate: assert property ((is_write(sfr, ADDR_TX_CTRL) && !sfr.wdata[TC_OUTPUT_DRIVE_DELAY])
        |=> q.drv_on == $past(sfr.wdata[TC_OUTPUT_DRIVE_ENABLE]))
        else $error("immediate drive change missed");
    a_rx_flush_empty: assert property ((is_write(sfr, ADDR_RX_CTRL) && sfr.wdata[FLUSH_BIT])
        |=> rx_cnt == 8'd0)
        else $error("receive flush left bytes");
    a_tx_flush_ptr: assert property ((is_write(sfr, ADDR_TX_CTRL) && sfr.wdata[FLUSH_BIT])
        |=> q.tp == q.op && tx_cnt == 8'd0)
        else $error("transmit flush failed");
    a_start_clear: assert property (is_write(sfr, ADDR_START)
        |=> tx_cnt == 8'd0 && rx_cnt == 8'd0 && q.lo == $past(sfr.wdata[6:0]))
        else $error("start write did not clear counts");
    a_tp_hold: assert property ((dwr && ring_inc(q.tp, q.lo, hi) == q.rp) |=> $stable(q.tp))
        else $error("transmit pointer ran into receive pointer");
    a_rp_advance: assert property ((sfr.rd && sfr.addr == ADDR_DATA && rx_cnt != 8'd0 && !sfr.wr)
        |=> q.rp == ring_inc($past(q.rp), $past(q.lo), $past(hi)))
        else $error("receive pointer did not advance");
    a_irq_output: assert property ((rx_irq && q.rx_ie) |=> aux_irq)
        else $error("receive interrupt not signalled");

    // A delayed drive change must wait for a byte end that has not yet come.
    sequence seq_delayed_drive_write;
        is_write(sfr, ADDR_TX_CTRL) && sfr.wdata[TC_OUTPUT_DRIVE_DELAY] &&
        !(tick && q.edge_idx == LAST_EDGE);
    endsequence

    a_drv_delay_hold: assert property (seq_delayed_drive_write |=> $stable(q.drv_on))
        else $error("delayed drive changed before byte end");
    a_master_miso_off: assert property (q.ctrl[CTL_MASTER] |-> pins_out.miso_oe_n)
        else $error("slave data output driven in master role");

endmodule : spi_fifo_port

// file: testbench/spi_peer.sv
// Behavioural external serial peer: mode 0, MSB first, echoes each byte it receives.
`timescale 1ns/10ps

module spi_peer (
    input  wire logic       sclk,
    input  wire logic       mosi,
    input  wire logic       sel_n,
    output logic            miso,
    output logic [7:0]      rx_byte,
    output logic [7:0]      got
);
    logic [7:0] shift_in;
    logic [7:0] reply;
    int         bits;

    initial begin
        reply = 8'ha5;
        bits = 0;
        got = 8'h00;
        rx_byte = 8'h00;
        miso = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Data is sampled on the rising edge only while selected.
    always @(posedge sclk) begin
        if (!sel_n) begin
            shift_in = {shift_in[6:0], mosi};
            bits = bits + 1;
            if (bits == 8) begin
                rx_byte = shift_in;
                reply = shift_in;
                got = got + 8'h01;
                bits = 0;
            end
        end
    end

    // Each bit appears on the falling edge, half a period before it is sampled.
    always @(negedge sclk) begin
        if (!sel_n)
            miso = reply[7 - bits];
    end

    always @(negedge sel_n) miso = reply[7];
    // A released line would float, so the inverse of the last bit stands in for it.
    always @(posedge sel_n) miso = ~miso;
endmodule : spi_peer

// file: testbench/tb_spi_fifo_port.sv
// Register-level testbench for the serial port with circular buffer.
`timescale 1ns/10ps

module tb_spi_fifo_port;
    import spi_fifo_pkg::*;

    logic       clk;
    logic       rst;
    sfr_req_t   sfr;
    logic [7:0] sfr_rdata;
    logic [3:0] port1_latch;
    pin_in_t    pins_in;
    pin_out_t   pins_out;
    logic       aux_irq;
    logic       ss_n;
    logic       miso_w;
    logic       sclk_w;
    logic [7:0] peer_rx;
    logic [7:0] peer_got;
    logic [7:0] v;
    logic       prev;
    int         half;
    int         run;
    int         failures;
    int         check_count;
    logic [7:0] rst_addr [9] = '{8'h9a, 8'h9c, 8'h9d, 8'h9e, 8'h9f, 8'ha5, 8'ha6, 8'ha7, 8'ha0};
    logic [7:0] rst_exp  [9] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h00, 8'h08, 8'h00, 8'h00};

    // The clock line is pulled low whenever its driver is off.
    assign sclk_w  = pins_out.sclk_oe_n ? 1'b0 : pins_out.sclk;
    assign pins_in = '{sclk: sclk_w, miso: miso_w, mosi: pins_out.mosi, ss_n: ss_n};

    spi_fifo_port u_spi_fifo_port (.clk(clk), .rst(rst), .sfr(sfr), .sfr_rdata(sfr_rdata),
        .port1_latch(port1_latch), .pins_in(pins_in), .pins_out(pins_out), .aux_irq(aux_irq));
    spi_peer u_spi_peer (.sclk(sclk_w), .mosi(pins_out.mosi), .sel_n(ss_n), .miso(miso_w),
        .rx_byte(peer_rx), .got(peer_got));

    always #25 clk = ~clk;

    // Length of the latest clock half period in system cycles.
    always @(posedge clk) begin
        if (pins_out.sclk !== prev) begin
            half = run;
            run = 1;
        end else
            run = run + 1;
        prev = pins_out.sclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        sfr.addr = a;
        sfr.wdata = d;
        sfr.wr = 1'b1;
        @(posedge clk);
        #1;
        sfr.wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        sfr.addr = a;
        sfr.rd = 1'b1;
        @(posedge clk);
        #1;
        sfr.rd = 1'b0;
        d = sfr_rdata;
    endtask : rd

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask : rchk

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic end_sim();
        $display("Checks %0d, errors %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    // Polls the receive count; giving up counts as a mismatch.
    task automatic wait_rx(input logic [7:0] n);
        logic [7:0] d;
        for (int i = 0; i < 400; i++) begin
            rd(ADDR_RX_CTRL, d);
            if (d === n)
                return;
        end
        chk(d, n);
        end_sim();
    endtask : wait_rx

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        sfr = '0;
        port1_latch = 4'hf;
        ss_n = 1'b1;
        prev = 1'b0;
        run = 0;
        half = 0;
        failures = 0;
        check_count = 0;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        for (int i = 0; i < 9; i++) rchk(rst_addr[i], rst_exp[i]);
        wr(ADDR_END, 8'h10);
        wr(ADDR_START, 8'h04);
        wr(ADDR_CONTROL, 8'h54);
        wr(ADDR_TX_CTRL, 8'h28);
        wr(ADDR_AUX_EN, 8'h0c);
        ss_n = 1'b0;
        wr(ADDR_DATA, 8'h3c);
        wr(ADDR_DATA, 8'h81);
        wr(ADDR_DATA, 8'h5b);
        rchk(ADDR_START, 8'h87);
        wait_rx(8'h03);
        chk(peer_got, 8'h03);
        chk(peer_rx, 8'h5b);
        chk(8'(half), 8'h04);
        rchk(ADDR_PENDING, {4'h0, PEND_RX});
        chk({7'h00, aux_irq}, 8'h01);
        rchk(ADDR_AUX_STAT, 8'h0c);
        rchk(ADDR_DATA, 8'ha5);
        rchk(ADDR_DATA, 8'h3c);
        rchk(ADDR_DATA, 8'h81);
        rd(ADDR_DATA, v);
        rchk(ADDR_END, 8'h87);
        rchk(ADDR_PENDING, {4'h0, PEND_TX});
        wr(ADDR_AUX_EN, 8'h00);
        rchk(ADDR_AUX_EN, 8'h08);
        rchk(ADDR_PENDING, 8'h00);
        chk({7'h00, aux_irq}, 8'h00);
        wr(ADDR_CONTROL, 8'h7c);
        wr(ADDR_RX_CTRL, 8'h01);
        wr(ADDR_DATA, 8'h01);
        wait_rx(8'h01);
        chk(peer_rx, 8'h80);
        chk(8'(half), 8'h08);
        rchk(ADDR_AUX_EN, 8'h08);
        wr(ADDR_DATA, 8'h02);
        wait_rx(8'h02);
        rchk(ADDR_AUX_EN, 8'h0c);
        rchk(ADDR_DATA, 8'hda);
        wr(ADDR_RX_CTRL, 8'h81);
        rchk(ADDR_RX_CTRL, 8'h00);
        wr(ADDR_DATA, 8'h03);
        wait_rx(8'h01);
        wr(ADDR_START, 8'h04);
        rchk(ADDR_RX_CTRL, 8'h00);
        rchk(ADDR_TX_CTRL, 8'h00);
        wr(ADDR_DATA, 8'h04);
        wait_rx(8'h01);
        wr(ADDR_CONTROL, 8'h7c);
        rchk(ADDR_RX_CTRL, 8'h00);
        rchk(ADDR_START, 8'h84);
        // Mode 3 in double buffer mode: three slots, so the third write is dropped.
        ss_n = 1'b1;
        wr(ADDR_CONTROL, 8'h47);
        ss_n = 1'b0;
        wr(ADDR_DATA, 8'h11);
        wr(ADDR_DATA, 8'h22);
        wr(ADDR_DATA, 8'h33);
        rchk(ADDR_START, 8'h86);
        wait_rx(8'h02);
        chk(peer_rx, 8'h22);
        chk(8'(half), 8'h04);
        rchk(ADDR_DATA, 8'h20);
        rchk(ADDR_DATA, 8'h11);
        wr(ADDR_DATA, 8'h44);
        rchk(ADDR_START, 8'h84);
        wait_rx(8'h01);
        rchk(ADDR_DATA, 8'h22);
        rchk(ADDR_END, 8'h84);
        // Flush the queued bytes while one is in flight, with a delayed drive off.
        ss_n = 1'b1;
        wr(ADDR_CONTROL, 8'h94);
        ss_n = 1'b0;
        wr(ADDR_DATA, 8'h55);
        wr(ADDR_DATA, 8'h66);
        wr(ADDR_DATA, 8'h77);
        rchk(ADDR_TX_CTRL, 8'h02);
        rchk(ADDR_AUX_EN, 8'h00);
        wr(ADDR_TX_CTRL, 8'hb1);
        rchk(ADDR_TX_CTRL, 8'h00);
        rchk(ADDR_AUX_EN, 8'h08);
        chk({7'h00, pins_out.mosi_oe_n}, 8'h00);
        wait_rx(8'h01);
        settle();
        chk({7'h00, pins_out.mosi_oe_n}, 8'h01);
        chk(peer_rx, 8'h55);
        chk(8'(half), 8'h10);
        ss_n = 1'b1;
        wr(ADDR_CONTROL, 8'h55);
        settle();
        chk({7'h00, pins_out.sclk}, 8'h01);
        wr(ADDR_TX_CTRL, 8'h08);
        settle();
        chk({7'h00, pins_out.sclk_oe_n}, 8'h01);
        chk({7'h00, pins_out.mosi_oe_n}, 8'h00);
        wr(ADDR_TX_CTRL, 8'h20);
        settle();
        chk({7'h00, pins_out.sclk_oe_n}, 8'h00);
        chk({7'h00, pins_out.mosi_oe_n}, 8'h01);
        port1_latch = 4'h7;
        settle();
        chk({7'h00, pins_out.sclk_oe_n}, 8'h01);
        end_sim();
    end
endmodule : tb_spi_fifo_port
